/* File: core/pll_freq_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_ratio_cfg.svh"

module pll_freq_div
    import pll_ratio_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             busy,
    output logic             done,
    output logic [31:0]      quotient
);

    logic [15:0] rem_reg;
    logic [31:0] quo_reg;
    logic [5:0]  step_reg;
    logic [16:0] rem_shift;
    logic        fits;

    // one restoring step per clock
    assign rem_shift = {rem_reg, quo_reg[31]};
    assign fits      = rem_shift >= {1'b0, divisor};

    // start restarts even mid-way, the newest operands win
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rem_reg  <= 16'h0000;
            quo_reg  <= 32'h0000_0000;
            step_reg <= 6'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_reg  <= 16'h0000;
                quo_reg  <= dividend;
                step_reg <= `PLL_DIV_STEPS;
                busy     <= 1'b1;
            end else if (busy) begin
                if (fits) begin
                    rem_reg <= 16'(rem_shift - {1'b0, divisor});
                end else begin
                    rem_reg <= rem_shift[15:0];
                end
                quo_reg  <= {quo_reg[30:0], fits};
                step_reg <= step_reg - 6'h01;
                if (step_reg == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign quotient = quo_reg;

endmodule

`default_nettype wire

/* File: core/pll_ratio_cfg.svh */
`ifndef PLL_RATIO_CFG_SVH
`define PLL_RATIO_CFG_SVH

// stored field widths
`define PLL_OD_W        3
`define PLL_FB_W        12
`define PLL_IN_W        6

// write port widths, one bit wider so out-of-range values can arrive
`define PLL_OD_WR_W     4
`define PLL_FB_WR_W     13
`define PLL_IN_WR_W     7

// boot defaults
`define PLL_OD_RST      3'h1
`define PLL_FB_RST      12'h03F
`define PLL_IN_RST      6'h00

// permitted maxima
`define PLL_OD_MAX      4'h7
`define PLL_FB_MAX      13'h0FFF
`define PLL_IN_MAX      7'h3F

// window on oscillator times multiplier over twice the input divider, in kHz (260 MHz .. 1.3 GHz)
`define PLL_VCO_MIN_KHZ 32'h0003_F7A0
`define PLL_VCO_MAX_KHZ 32'h0013_D620

// serial divider length
`define PLL_DIV_STEPS   6'h20

`endif

/* File: core/pll_ratio_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_ratio_cfg.svh"

module pll_ratio_config
    import pll_ratio_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    cfg_wr,
    input  wire logic [`PLL_OD_WR_W-1:0] cfg_output_divider,
    input  wire logic [`PLL_FB_WR_W-1:0] cfg_feedback,
    input  wire logic [`PLL_IN_WR_W-1:0] cfg_input_div,
    input  wire logic [15:0]             osc_freq_khz,
    output logic [`PLL_OD_W-1:0]         output_divider,
    output logic [`PLL_FB_W-1:0]         feedback_mult,
    output logic [`PLL_IN_W-1:0]         input_div,
    output logic                         cfg_accept,
    output logic                         cfg_reject,
    output logic                         freq_valid,
    output logic [31:0]                  tile_freq_khz,
    output logic [31:0]                  switch_freq_khz,
    output logic [31:0]                  ref_src_freq_khz
);

    calc_state_t          state_reg;
    logic [`PLL_OD_W-1:0] od_reg;
    logic [`PLL_FB_W-1:0] fb_reg;
    logic [`PLL_IN_W-1:0] in_reg;
    logic [31:0]          freq_reg;
    logic [31:0]          dividend_reg;
    logic [15:0]          divisor_reg;
    logic                 valid_reg;
    logic                 accept_reg;
    logic                 reject_reg;

    logic [13:0]          wr_fb_plus;
    logic [7:0]           wr_in_plus;
    logic [31:0]          wr_vco_prod;
    logic [31:0]          wr_vco_lo;
    logic [31:0]          wr_vco_hi;
    logic                 fields_ok;
    logic                 vco_ok;
    logic                 accept;
    logic [12:0]          st_fb_plus;
    logic [6:0]           st_in_plus;
    logic [3:0]           st_od_plus;
    logic                 div_start;
    logic                 calc_done;
    logic                 launched_reg;
    logic                 div_done;
    logic [31:0]          div_quo;

    assign fields_ok = (cfg_output_divider <= `PLL_OD_MAX)
                    && (cfg_feedback <= `PLL_FB_MAX)
                    && (cfg_input_div <= `PLL_IN_MAX);

    // vco window compared as products, so no divider sits in the write path
    assign wr_fb_plus  = {1'b0, cfg_feedback} + 14'h0001;
    assign wr_in_plus  = {1'b0, cfg_input_div} + 8'h01;
    assign wr_vco_prod = 32'({16'h0000, osc_freq_khz}
                             * {18'h0_0000, wr_fb_plus});
    assign wr_vco_lo   = `PLL_VCO_MIN_KHZ * {23'h00_0000, wr_in_plus, 1'b0};
    assign wr_vco_hi   = `PLL_VCO_MAX_KHZ * {23'h00_0000, wr_in_plus, 1'b0};
    assign vco_ok = (wr_vco_prod >= wr_vco_lo) && (wr_vco_prod <= wr_vco_hi);
    assign accept = cfg_wr && fields_ok && vco_ok;

    // divider settings, defaults on reset, replaced by legal writes only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            od_reg <= `PLL_OD_RST;
            fb_reg <= `PLL_FB_RST;
            in_reg <= `PLL_IN_RST;
        end else if (accept) begin
            od_reg <= cfg_output_divider[`PLL_OD_W-1:0];
            fb_reg <= cfg_feedback[`PLL_FB_W-1:0];
            in_reg <= cfg_input_div[`PLL_IN_W-1:0];
        end
    end

    // write outcome pulses
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accept_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            accept_reg <= accept;
            reject_reg <= cfg_wr && !accept;
        end
    end

    // operands from the stored settings
    assign st_fb_plus = {1'b0, fb_reg} + 13'h0001;
    assign st_in_plus = {1'b0, in_reg} + 7'h01;
    assign st_od_plus = {1'b0, od_reg} + 4'h1;

    // recalculation sequencer; osc changes are only seen on the next accepted write or reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= CALC_START;
        end else if (accept) begin
            state_reg <= CALC_START;
        end else begin
            case (state_reg)
                CALC_START: state_reg <= CALC_BUSY;
                CALC_BUSY:  state_reg <= calc_done ? CALC_IDLE : CALC_BUSY;
                CALC_IDLE:  state_reg <= CALC_IDLE;
                default:    state_reg <= CALC_IDLE;
            endcase
        end
    end

    // latch numerator and denominator of the ratio
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dividend_reg <= 32'h0000_0000;
            divisor_reg  <= 16'h0001;
        end else if (state_reg == CALC_START) begin
            dividend_reg <= 32'({16'h0000, osc_freq_khz}
                                * {19'h0_0000, st_fb_plus});
            divisor_reg  <= {4'h0,
                             11'({4'h0, st_in_plus} * {7'h00, st_od_plus}),
                             1'b0};
        end
    end

    // launch bookkeeping; an accepted write clears it so that the done of an aborted
    // run is never taken for the result of the new settings
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            launched_reg <= 1'b0;
        end else if (accept || state_reg == CALC_START) begin
            launched_reg <= 1'b0;
        end else if (div_start) begin
            launched_reg <= 1'b1;
        end
    end

    // a start mid-run restarts the divider with the newest operands
    assign div_start = (state_reg == CALC_BUSY) && !launched_reg && !accept;
    assign calc_done = div_done && launched_reg;

    pll_freq_div u_div (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .start    (div_start),
        .dividend (dividend_reg),
        .divisor  (divisor_reg),
        .busy     (),
        .done     (div_done),
        .quotient (div_quo)
    );

    // result and its validity; an accepted write invalidates at once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            freq_reg  <= 32'h0000_0000;
            valid_reg <= 1'b0;
        end else if (accept || state_reg == CALC_START) begin
            valid_reg <= 1'b0;
        end else if (calc_done && state_reg == CALC_BUSY) begin
            freq_reg  <= div_quo;
            valid_reg <= 1'b1;
        end
    end

    assign output_divider = od_reg;
    assign feedback_mult  = fb_reg;
    assign input_div      = in_reg;
    assign cfg_accept     = accept_reg;
    assign cfg_reject     = reject_reg;
    assign freq_valid     = valid_reg;
    // one source fans out to all three consumers
    assign tile_freq_khz    = freq_reg;
    assign switch_freq_khz  = freq_reg;
    assign ref_src_freq_khz = freq_reg;

    chk_reset_defaults: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !$past(rst_n) |-> (od_reg == `PLL_OD_RST && fb_reg == `PLL_FB_RST
                           && in_reg == `PLL_IN_RST))
        else $error("settings not at defaults after reset");

    chk_write_loads: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_wr && fields_ok && vco_ok) |=>
        ({1'b0, od_reg} == $past(cfg_output_divider)
         && {1'b0, fb_reg} == $past(cfg_feedback)
         && {1'b0, in_reg} == $past(cfg_input_div) && cfg_accept))
        else $error("legal write did not load settings");

    chk_bad_write_kept: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_wr && !(fields_ok && vco_ok)) |=>
        ($stable(od_reg) && $stable(fb_reg) && $stable(in_reg) && cfg_reject))
        else $error("refused write changed settings");

    chk_range_refused: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_wr && (cfg_output_divider > 4'h7 || cfg_feedback > 13'h0FFF
                    || cfg_input_div > 7'h3F)) |=> (cfg_reject && !cfg_accept))
        else $error("out-of-range write not refused");

    chk_freq_equation: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(freq_valid) |->
        ({32'h0, freq_reg} * {48'h0, divisor_reg} <= {32'h0, dividend_reg}
         && {32'h0, dividend_reg}
            < ({32'h0, freq_reg} + 64'h1) * {48'h0, divisor_reg}))
        else $error("tile frequency breaks ratio equation");

    // write invalidates, then result returns within bound
    chk_recalc_bound: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept ##1 (!cfg_wr)[*8]) |-> (!freq_valid)[*8] ##[1:40]
        (freq_valid || cfg_wr))
        else $error("recalculation not bounded");

    chk_clock_fanout: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (switch_freq_khz == tile_freq_khz && ref_src_freq_khz == tile_freq_khz))
        else $error("clock consumers disagree");

endmodule

`default_nettype wire

/* File: core/pll_ratio_pkg.sv */
package pll_ratio_pkg;

    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_START,
        CALC_BUSY
    } calc_state_t;

endpackage

/* File: tb/tb_pll_ratio_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pll_ratio_cfg.svh"

module tb;
    logic                    clk_sys;
    logic                    rst_n;
    logic                    cfg_wr;
    logic [`PLL_OD_WR_W-1:0] cfg_od;
    logic [`PLL_FB_WR_W-1:0] cfg_fb;
    logic [`PLL_IN_WR_W-1:0] cfg_in;
    logic [15:0]             osc_freq_khz;
    logic [`PLL_OD_W-1:0]    output_divider;
    logic [`PLL_FB_W-1:0]    feedback_mult;
    logic [`PLL_IN_W-1:0]    input_div;
    logic                    cfg_accept;
    logic                    cfg_reject;
    logic                    freq_valid;
    logic [31:0]             tile_f;
    logic [31:0]             switch_f;
    logic [31:0]             ref_f;
    logic [`PLL_OD_W-1:0]    cur_od;
    logic [`PLL_FB_W-1:0]    cur_fb;
    logic [`PLL_IN_W-1:0]    cur_in;
    int                      num_errors;
    int                      n_checks;

    pll_ratio_config dut (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .cfg_wr             (cfg_wr),
        .cfg_output_divider (cfg_od),
        .cfg_feedback       (cfg_fb),
        .cfg_input_div      (cfg_in),
        .osc_freq_khz       (osc_freq_khz),
        .output_divider     (output_divider),
        .feedback_mult      (feedback_mult),
        .input_div          (input_div),
        .cfg_accept         (cfg_accept),
        .cfg_reject         (cfg_reject),
        .freq_valid         (freq_valid),
        .tile_freq_khz      (tile_f),
        .switch_freq_khz    (switch_f),
        .ref_src_freq_khz   (ref_f)
    );

    // free-running 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t value got %0d exp %0d", $time, got, exp);
        end
    endtask

    // expectation worked out independently, floor division in kHz
    function automatic logic [31:0] expf(input logic [3:0] od,
            input logic [12:0] f, input logic [6:0] r);
        expf = (32'(osc_freq_khz) * (f + 1)) / (2 * (r + 1) * (od + 1));
    endfunction

    task automatic chk_set();
        cmp_word(32'(output_divider), 32'(cur_od));
        cmp_word(32'(feedback_mult), 32'(cur_fb));
        cmp_word(32'(input_div), 32'(cur_in));
    endtask

    task automatic chk_freq(input logic [31:0] f);
        cmp_word(tile_f, f);
        cmp_word(switch_f, f);
        cmp_word(ref_f, f);
    endtask

    // bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_valid();
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_sys);
            #5;
            if (freq_valid === 1'b1) return;
        end
        num_errors++;
        $display("[ERR] %0t frequency never became valid", $time);
        results();
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        #5;
        cur_od = 3'h1;
        cur_fb = 12'h03F;
        cur_in = 6'h00;
        chk_set();
        cmp_bit(freq_valid, 1'b0);
        rst_n = 1'b1;
    endtask

    task automatic send(input logic [3:0] od, input logic [12:0] f,
            input logic [6:0] r);
        cfg_wr = 1'b1;
        cfg_od = od;
        cfg_fb = f;
        cfg_in = r;
        @(posedge clk_sys);
        #5;
    endtask

    // one write, then the pulse, settings and valid flag one cycle on
    task automatic write(input logic [3:0] od, input logic [12:0] f,
            input logic [6:0] r, input logic ok);
        send(od, f, r);
        cfg_wr = 1'b0;
        cmp_bit(cfg_accept, ok);
        cmp_bit(cfg_reject, ~ok);
        cmp_bit(freq_valid, ~ok);
        if (ok) begin
            cur_od = od[2:0];
            cur_fb = f[11:0];
            cur_in = r[5:0];
        end
        chk_set();
        @(posedge clk_sys);
        #5;
        cmp_bit(cfg_accept, 1'b0);
        cmp_bit(cfg_reject, 1'b0);
    endtask

    task automatic t_boot();
        do_reset();
        wait_valid();
        chk_freq(32'h0004_E200);
    endtask

    // legal writes, including every field at its maximum and VCO edge
    task automatic t_accept();
        write(4'h0, 13'h0063, 7'h01, 1'b1);
        wait_valid();
        chk_freq(expf(4'h0, 13'h0063, 7'h01));
        write(4'h7, 13'h0FFF, 7'h3F, 1'b1);
        wait_valid();
        chk_freq(expf(4'h7, 13'h0FFF, 7'h3F));
        write(4'h0, 13'h0019, 7'h00, 1'b1);
        wait_valid();
        chk_freq(expf(4'h0, 13'h0019, 7'h00));
    endtask

    // each field one past its limit, then VCO just below and above
    task automatic t_refuse();
        logic [31:0] keep;
        keep = tile_f;
        write(4'h8, 13'h0063, 7'h01, 1'b0);
        write(4'h0, 13'h1000, 7'h01, 1'b0);
        write(4'h0, 13'h0063, 7'h40, 1'b0);
        write(4'h0, 13'h0018, 7'h00, 1'b0);
        write(4'h0, 13'h0082, 7'h00, 1'b0);
        chk_freq(keep);
    endtask

    // a second write on the next edge must replace the first
    task automatic t_b2b();
        send(4'h1, 13'h0063, 7'h01);
        cmp_bit(cfg_accept, 1'b1);
        send(4'h3, 13'h0081, 7'h00);
        cfg_wr = 1'b0;
        cmp_bit(cfg_accept, 1'b1);
        cur_od = 3'h3;
        cur_fb = 12'h081;
        cur_in = 6'h00;
        chk_set();
        wait_valid();
        chk_freq(expf(4'h3, 13'h0081, 7'h00));
    endtask

    // a write while the divider runs must abort the stale result
    task automatic t_abort();
        write(4'h1, 13'h0063, 7'h01, 1'b1);
        repeat (8) @(posedge clk_sys);
        #5;
        cmp_bit(freq_valid, 1'b0);
        write(4'h0, 13'h0063, 7'h01, 1'b1);
        wait_valid();
        chk_freq(expf(4'h0, 13'h0063, 7'h01));
    endtask

    // reset in mid calculation brings the boot settings back
    task automatic t_rst_mid();
        write(4'h2, 13'h0063, 7'h00, 1'b1);
        do_reset();
        wait_valid();
        chk_freq(32'h0004_E200);
    endtask

    initial begin
        num_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        cfg_wr = 1'b0;
        cfg_od = 4'h0;
        cfg_fb = 13'h0000;
        cfg_in = 7'h00;
        osc_freq_khz = 16'h4E20;
        @(posedge clk_sys);
        #5;
        t_boot();
        t_accept();
        t_refuse();
        t_b2b();
        t_abort();
        t_rst_mid();
        results();
    end
endmodule

`default_nettype wire
